// ===== rtl/reset_boot_pkg.sv
package reset_boot_pkg;
   // Clock period in nanoseconds (10 MHz).
   localparam int CLK_PERIOD_NS = 100;
   localparam int LATCH_LOAD_MAX_NS = 10000;
   localparam int LATCH_LOAD_CYCLES = LATCH_LOAD_MAX_NS / CLK_PERIOD_NS;
   localparam int HOLDOFF_NS = 20000;
   localparam int HOLDOFF_CYCLES = HOLDOFF_NS / CLK_PERIOD_NS;
   // The latch load takes fewer cycles than its limit to leave margin.
   localparam int LATCH_WORDS = 8;
   localparam int SRAM_SCRATCH_FIRST = 0;
   localparam int SRAM_SCRATCH_LAST = 127;
   localparam logic [31:0] USER_START_ADDR = 32'h0000_0000;
   localparam logic [2:0] DRIVE_MODE_RESET = 3'h0;
   localparam logic [7:0] CHECKSUM_SEED = 8'h00;

   typedef enum logic [3:0] {
      ST_POWER_WAIT = 4'h0,
      ST_LATCH_LOAD = 4'h1,
      ST_RESET_HOLD = 4'h2,
      ST_HOLDOFF = 4'h3,
      ST_COPY = 4'h4,
      ST_CHECK = 4'h5,
      ST_APPLY = 4'h6,
      ST_DEBUG = 4'h7,
      ST_USER = 4'h8
   } seq_state_type;
endpackage

// ===== rtl/boot_mem_if.sv
`timescale 1ns/1ps
// Carries the copy, checksum and apply handshakes between sequencer and mover.
interface boot_mem_if;
   logic start;
   logic busy;
   logic done;
   logic sumOk;
   logic applyStart;
   logic applyDone;
   modport seq (output start, output applyStart, input busy, input done, input sumOk, input applyDone);
   modport mover (input start, input applyStart, output busy, output done, output sumOk, output applyDone);
endinterface

// ===== rtl/boot_dma_mover.sv
`timescale 1ns/1ps
module boot_dma_mover
   import reset_boot_pkg::*;
#(
   parameter int WORDS = 16
)
(
   input wire logic clk, // System clock.
   input wire logic rst, // Asynchronous reset.
   boot_mem_if.mover mem, // Control from the sequencer.
   output logic [7:0] hubAddr, // Bus hub address.
   output logic hubRead, // Flash read strobe.
   input wire logic [7:0] hubRdata, // Flash data, same clock.
   input wire logic [7:0] storedSum, // Expected checksum from flash.
   output logic hubWrite, // Register write strobe.
   output logic [7:0] hubWdata // Register write data.
);
   logic [7:0] scratch [0:WORDS-1];
   logic [$clog2(WORDS):0] idx_reg;
   logic [7:0] sum_reg;
   logic copying_reg;
   logic applying_reg;

   initial
   begin
      // The word index needs at least one bit, so a single-word copy is refused.
      if (WORDS < 2 || WORDS > SRAM_SCRATCH_LAST - SRAM_SCRATCH_FIRST + 1)
      begin
         $error("WORDS must fit the scratch area");
      end
   end

   // Copy into scratch SRAM while the checksum unit accumulates. (RL13) (RL14)
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         idx_reg <= '0;
         copying_reg <= 1'b0;
         applying_reg <= 1'b0;
         sum_reg <= CHECKSUM_SEED;
      end
      else if (mem.start && !copying_reg && !applying_reg)
      begin
         idx_reg <= '0;
         copying_reg <= 1'b1;
         sum_reg <= CHECKSUM_SEED;
      end
      else if (copying_reg)
      begin
         sum_reg <= sum_reg + hubRdata;
         if (idx_reg == ($clog2(WORDS)+1)'(WORDS - 1))
         begin
            copying_reg <= 1'b0;
         end
         else
         begin
            idx_reg <= idx_reg + 1'b1;
         end
      end
      else if (mem.applyStart && !applying_reg)
      begin
         idx_reg <= '0;
         applying_reg <= 1'b1;
      end
      else if (applying_reg)
      begin
         if (idx_reg == ($clog2(WORDS)+1)'(WORDS - 1))
         begin
            applying_reg <= 1'b0;
         end
         else
         begin
            idx_reg <= idx_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (copying_reg)
      begin
         scratch[idx_reg[$clog2(WORDS)-1:0]] <= hubRdata; // RL13
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mem.done <= 1'b0;
         mem.applyDone <= 1'b0;
         hubWrite <= 1'b0;
         hubWdata <= 8'h00;
      end
      else
      begin
         mem.done <= copying_reg && idx_reg == ($clog2(WORDS)+1)'(WORDS - 1);
         mem.applyDone <= applying_reg && idx_reg == ($clog2(WORDS)+1)'(WORDS - 1);
         hubWrite <= applying_reg; // RL14
         hubWdata <= scratch[idx_reg[$clog2(WORDS)-1:0]];
      end
   end

   assign mem.busy = copying_reg || applying_reg;
   assign mem.sumOk = (sum_reg == storedSum); // RL14
   assign hubRead = copying_reg;
   assign hubAddr = 8'(idx_reg);
endmodule

// ===== rtl/reset_boot_sequencer.sv
`timescale 1ns/1ps
// Contract
// (RL1) Start latch load once supply is good; finish within 10 us.
// (RL2) Latch load sets I/O drive modes and config, then enter reset.
// (RL3) Stay in reset while external reset is held low.
// (RL4) Reset released and supplies good starts the hold-off sequence.
// (RL5) Hold-off runs on fast-startup oscillator until reset release.
// (RL6) Hold-off keeps reset for about 20 us.
// (RL7) References not ready at end of hold-off restart the reset cycle.
// (RL8) On release switch to precise oscillator, start bus clock, begin boot.
// (RL9) Debug pins toggling during boot enter debug mode, otherwise user mode.
// (RL10) Manufacturing and device latches load together in reset.
// (RL11) Trim outputs valid before the device leaves reset.
// (RL12) Device latch contents give I/O drive-mode reset values.
// (RL13) DMA copies flash config through the hub into scratch SRAM.
// (RL14) Checksum passes before DMA writes target config registers.
// (RL15) Failed checksum triggers system reset and restarts sequence.
// (RL16) Boot loads only the default-mode oscillator trim.
// (RL17) CPU halted throughout boot; only DMA, hub, checksum move data.
// (RL18) User mode releases CPU fetching from address zero.
// (RL19) Hold-off is a counter sampled for readiness at terminal count.
// (RL20) External reset is active low, holding reset while low.
module reset_boot_sequencer
   import reset_boot_pkg::*;
#(
   parameter int HOLDOFF_COUNT = HOLDOFF_CYCLES,
   parameter int BOOT_WORDS = 16
)
(
   input wire logic clk, // System clock, 10 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic supplyGood, // Supply monitors, asynchronous.
   input wire logic external_reset_n, // External reset pin, active low.
   input wire logic refsReady, // Band-gap and precision reset ready.
   input wire logic debug_acquire_pin_a, // Debug acquire pin A.
   input wire logic debug_acquire_pin_b, // Debug acquire pin B.
   input wire logic [7:0] mfgLatch, // Manufacturing trim latch word.
   input wire logic [7:0] devLatch, // Device configuration latch word.
   output logic [7:0] hubAddr, // Bus hub address.
   output logic hubRead, // Flash read strobe.
   input wire logic [7:0] hubRdata, // Flash read data.
   input wire logic [7:0] storedSum, // Expected checksum.
   output logic hubWrite, // Config register write strobe.
   output logic [7:0] hubWdata, // Config register write data.
   output logic [7:0] porTrim, // Trim for power-on reset circuit.
   output logic [2:0] ioDriveMode, // Reset drive mode for I/O.
   output logic systemReset, // Device held in reset.
   output logic fastOscOn, // Fast-startup oscillator running, during hold-off only.
   output logic preciseOscOn, // Precise oscillator running.
   output logic preciseOsc48, // Precise oscillator at 48 MHz, else 12 MHz.
   output logic busClockOn, // System bus clock running.
   output logic cpuHalt, // CPU held halted.
   output logic [31:0] cpuStartAddr, // CPU reset fetch address.
   output logic debugMode, // Debug mode entered.
   output logic userMode // User mode entered.
);
   seq_state_type state_reg;
   seq_state_type state_next;
   logic [$clog2(HOLDOFF_COUNT+1)-1:0] count_reg;
   logic [$clog2(LATCH_LOAD_CYCLES+1)-1:0] loadCount_reg;
   logic [1:0] supplySync_reg;
   logic [1:0] resetSync_reg;
   logic [1:0] refsSync_reg;
   logic [1:0] pinASync_reg;
   logic [1:0] pinBSync_reg;
   logic pinAPrev_reg;
   logic pinBPrev_reg;
   logic sawA_reg;
   logic sawB_reg;
   logic holdoffEnd;
   logic sumOkLatched_reg;
   logic speedSel_reg;
   boot_mem_if mem();

   initial
   begin
      if (HOLDOFF_COUNT < 1 || BOOT_WORDS < 2 || BOOT_WORDS > SRAM_SCRATCH_LAST - SRAM_SCRATCH_FIRST + 1)
      begin
         $error("HOLDOFF_COUNT must be positive and BOOT_WORDS must fit the scratch area");
      end
   end

   // Pins and monitors come from outside the clock domain.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         supplySync_reg <= 2'h0;
         resetSync_reg <= 2'h0;
         refsSync_reg <= 2'h0;
         pinASync_reg <= 2'h0;
         pinBSync_reg <= 2'h0;
      end
      else
      begin
         supplySync_reg <= {supplySync_reg[0], supplyGood};
         resetSync_reg <= {resetSync_reg[0], external_reset_n};
         refsSync_reg <= {refsSync_reg[0], refsReady};
         pinASync_reg <= {pinASync_reg[0], debug_acquire_pin_a};
         pinBSync_reg <= {pinBSync_reg[0], debug_acquire_pin_b};
      end
   end

   assign holdoffEnd = (count_reg == ($clog2(HOLDOFF_COUNT+1))'(HOLDOFF_COUNT - 1));

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_POWER_WAIT:
            if (supplySync_reg[1])
            begin
               state_next = ST_LATCH_LOAD; // RL1
            end
         ST_LATCH_LOAD:
            if (loadCount_reg == ($clog2(LATCH_LOAD_CYCLES+1))'(LATCH_WORDS - 1))
            begin
               state_next = ST_RESET_HOLD; // RL2
            end
         ST_RESET_HOLD:
            if (resetSync_reg[1] && supplySync_reg[1])
            begin
               state_next = ST_HOLDOFF; // RL4
            end
         ST_HOLDOFF:
            if (!resetSync_reg[1] || !supplySync_reg[1])
            begin
               state_next = ST_RESET_HOLD; // RL3
            end
            else if (holdoffEnd)
            begin
               // A failed reference check restarts hold-off from zero.
               state_next = refsSync_reg[1] ? ST_COPY : ST_HOLDOFF; // RL7
            end
         ST_COPY:
            if (mem.done)
            begin
               state_next = ST_CHECK;
            end
         ST_CHECK:
            state_next = sumOkLatched_reg ? ST_APPLY : ST_RESET_HOLD; // RL15
         ST_APPLY:
            if (mem.applyDone)
            begin
               state_next = (sawA_reg && sawB_reg) ? ST_DEBUG : ST_USER; // RL9
            end
         default:
            state_next = state_reg;
      endcase
      // The pin overrides any later phase; returning here reruns hold-off.
      if (state_reg != ST_POWER_WAIT && state_reg != ST_LATCH_LOAD && !resetSync_reg[1])
      begin
         state_next = ST_RESET_HOLD; // RL20
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ST_POWER_WAIT;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Hold-off counter; it clears whenever hold-off ends or restarts.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_reg <= '0;
      end
      else if (state_reg != ST_HOLDOFF || holdoffEnd)
      begin
         count_reg <= '0; // RL19
      end
      else
      begin
         count_reg <= count_reg + 1'b1; // RL6
      end
   end

   // Both latch kinds load together; values stay stable for the trim users.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loadCount_reg <= '0;
         porTrim <= 8'h00;
         ioDriveMode <= DRIVE_MODE_RESET;
         speedSel_reg <= 1'b0;
      end
      else if (state_reg == ST_LATCH_LOAD)
      begin
         loadCount_reg <= loadCount_reg + 1'b1; // RL1
         porTrim <= mfgLatch; // RL10 RL11
         ioDriveMode <= devLatch[2:0]; // RL12 RL2
         speedSel_reg <= devLatch[3]; // RL16
      end
      else
      begin
         loadCount_reg <= '0;
      end
   end

   // Debug acquire needs both pins to toggle while boot runs.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pinAPrev_reg <= 1'b0;
         pinBPrev_reg <= 1'b0;
         sawA_reg <= 1'b0;
         sawB_reg <= 1'b0;
      end
      else
      begin
         pinAPrev_reg <= pinASync_reg[1];
         pinBPrev_reg <= pinBSync_reg[1];
         if (state_reg == ST_HOLDOFF)
         begin
            sawA_reg <= 1'b0;
            sawB_reg <= 1'b0;
         end
         else if (state_reg == ST_COPY || state_reg == ST_CHECK || state_reg == ST_APPLY)
         begin
            sawA_reg <= sawA_reg || (pinASync_reg[1] != pinAPrev_reg); // RL9
            sawB_reg <= sawB_reg || (pinBSync_reg[1] != pinBPrev_reg); // RL9
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sumOkLatched_reg <= 1'b0;
      end
      else if (mem.done)
      begin
         sumOkLatched_reg <= mem.sumOk; // RL14
      end
   end

   assign mem.start = (state_reg == ST_COPY) && !mem.busy && !mem.done;
   assign mem.applyStart = (state_reg == ST_CHECK) && sumOkLatched_reg; // RL14

   boot_dma_mover #(
      .WORDS(BOOT_WORDS)
   ) mover (
      .clk(clk),
      .rst(rst),
      .mem(mem),
      .hubAddr(hubAddr),
      .hubRead(hubRead),
      .hubRdata(hubRdata),
      .storedSum(storedSum),
      .hubWrite(hubWrite),
      .hubWdata(hubWdata)
   );

   // Phase outputs are registered from the next state so they align with it.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         systemReset <= 1'b1;
         fastOscOn <= 1'b0;
         preciseOscOn <= 1'b0;
         preciseOsc48 <= 1'b0;
         busClockOn <= 1'b0;
         cpuHalt <= 1'b1;
         cpuStartAddr <= USER_START_ADDR;
         debugMode <= 1'b0;
         userMode <= 1'b0;
      end
      else
      begin
         systemReset <= state_next inside {ST_POWER_WAIT, ST_LATCH_LOAD, ST_RESET_HOLD, ST_HOLDOFF}; // RL3
         fastOscOn <= state_next == ST_HOLDOFF; // RL5
         preciseOscOn <= state_next inside {ST_COPY, ST_CHECK, ST_APPLY, ST_DEBUG, ST_USER}; // RL8
         preciseOsc48 <= speedSel_reg; // RL16
         busClockOn <= state_next inside {ST_COPY, ST_CHECK, ST_APPLY, ST_DEBUG, ST_USER}; // RL8
         cpuHalt <= state_next != ST_USER; // RL17
         cpuStartAddr <= USER_START_ADDR; // RL18
         debugMode <= state_next == ST_DEBUG; // RL9
         userMode <= state_next == ST_USER; // RL18
      end
   end

   property p_latch_bound;
      @(posedge clk) disable iff (rst)
      $rose(state_reg == ST_LATCH_LOAD) |-> ##[1:100] state_reg != ST_LATCH_LOAD;
   endproperty
   a_latch_bound: assert property (p_latch_bound) else $error("latch load overran"); // RL1

   property p_hold_low;
      @(posedge clk) disable iff (rst)
      !resetSync_reg[1] && state_reg != ST_POWER_WAIT |-> ##1 systemReset;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("reset not held while pin low"); // RL20

   property p_no_fast_after;
      @(posedge clk) disable iff (rst)
      preciseOscOn |-> !fastOscOn && !systemReset;
   endproperty
   a_no_fast_after: assert property (p_no_fast_after) else $error("oscillator modes overlap"); // RL8

   property p_restart;
      @(posedge clk) disable iff (rst)
      state_reg == ST_HOLDOFF && holdoffEnd && !refsSync_reg[1] && resetSync_reg[1] && supplySync_reg[1]
         |=> state_reg == ST_HOLDOFF && count_reg == 0;
   endproperty
   a_restart: assert property (p_restart) else $error("hold-off not restarted"); // RL7

   property p_fail_reset;
      @(posedge clk) disable iff (rst)
      state_reg == ST_CHECK && !sumOkLatched_reg |=> state_reg == ST_RESET_HOLD;
   endproperty
   a_fail_reset: assert property (p_fail_reset) else $error("bad checksum did not reset"); // RL15

   property p_write_after_check;
      @(posedge clk) disable iff (rst)
      hubWrite |-> sumOkLatched_reg;
   endproperty
   a_write_after_check: assert property (p_write_after_check) else $error("write before checksum"); // RL14

   property p_cpu_halt;
      @(posedge clk) disable iff (rst)
      state_reg inside {ST_COPY, ST_CHECK, ST_APPLY} |-> cpuHalt;
   endproperty
   a_cpu_halt: assert property (p_cpu_halt) else $error("cpu ran during boot"); // RL17

   property p_user_start;
      @(posedge clk) disable iff (rst)
      userMode |-> !cpuHalt && cpuStartAddr == 32'h0000_0000;
   endproperty
   a_user_start: assert property (p_user_start) else $error("user mode start wrong"); // RL18

   c_user: cover property (@(posedge clk) disable iff (rst) $rose(userMode));
   c_debug: cover property (@(posedge clk) disable iff (rst) $rose(debugMode));
   c_cksum_fail: cover property (@(posedge clk) disable iff (rst) state_reg == ST_CHECK && !sumOkLatched_reg);
   c_refs_restart: cover property (@(posedge clk) disable iff (rst) state_reg == ST_HOLDOFF && holdoffEnd && !refsSync_reg[1]);
endmodule

// ===== bench/boot_partner_model.sv
`timescale 1ns/1ps
// Stands in for the reset pin, the supply monitors, the debug host and the reserved flash.
module boot_partner_model
#(
   parameter int WORDS = 4
)
(
   input wire logic clk, // System clock.
   input wire logic powerOn, // Supplies have reached their level.
   input wire logic holdPin, // Hold the reset pin low.
   input wire logic refsOk, // References settle in time.
   input wire logic acquire, // Debug host toggles the acquire pins.
   input wire logic corrupt, // Flash checksum is wrong.
   input wire logic hubRead, // Flash read strobe.
   input wire logic [7:0] hubAddr, // Flash word index.
   output logic supplyGood, // Supply monitor level.
   output logic external_reset_n, // Reset pin, low holds reset.
   output logic refsReady, // References ready.
   output logic debug_acquire_pin_a, // Debug acquire pin A.
   output logic debug_acquire_pin_b, // Debug acquire pin B.
   output logic [7:0] hubRdata, // Flash data.
   output logic [7:0] storedSum // Expected checksum.
);
   logic [7:0] lastData;
   logic [7:0] sum;

   assign supplyGood = powerOn;
   assign external_reset_n = ~holdPin;
   assign refsReady = refsOk;
   // A released data bus shows the inverse of its last value, so stale data never matches.
   assign hubRdata = hubRead ? 8'h3C + hubAddr * 8'h11 : ~lastData;

   initial
   begin
      debug_acquire_pin_a = 1'b0;
      debug_acquire_pin_b = 1'b0;
      lastData = 8'h00;
   end

   always @(posedge clk)
   begin
      lastData <= hubRdata;
      if (acquire)
      begin
         debug_acquire_pin_a <= ~debug_acquire_pin_a;
         debug_acquire_pin_b <= ~debug_acquire_pin_b;
      end
   end

   always_comb
   begin
      sum = 8'h00;
      for (int i = 0; i < WORDS; i++)
         sum = sum + 8'h3C + 8'(i) * 8'h11;
      storedSum = corrupt ? ~sum : sum;
   end
endmodule

// ===== bench/reset_boot_sequencer_bench.sv
`timescale 1ns/1ps
module reset_boot_sequencer_bench;
   import reset_boot_pkg::*;
   localparam int WORDS = 4;
   logic clk, rst, powerOn, holdPin, refsOk, acquire, corrupt;
   logic supplyGood, external_reset_n, refsReady, pinA, pinB, hubRead, hubWrite;
   logic [7:0] hubAddr, hubRdata, storedSum, hubWdata, porTrim, mfgLatch, devLatch;
   logic [2:0] ioDriveMode;
   logic systemReset, fastOscOn, preciseOscOn, preciseOsc48, busClockOn, cpuHalt, debugMode, userMode;
   logic [31:0] cpuStartAddr;
   int badCount, comparisons;
   logic [7:0] rdq[$];
   logic [7:0] wrq[$];
   logic sawFast, earlyWrite;

   reset_boot_sequencer #(.HOLDOFF_COUNT(4), .BOOT_WORDS(WORDS)) dut (
      .clk(clk), .rst(rst), .supplyGood(supplyGood), .external_reset_n(external_reset_n),
      .refsReady(refsReady), .debug_acquire_pin_a(pinA), .debug_acquire_pin_b(pinB),
      .mfgLatch(mfgLatch), .devLatch(devLatch), .hubAddr(hubAddr), .hubRead(hubRead),
      .hubRdata(hubRdata), .storedSum(storedSum), .hubWrite(hubWrite), .hubWdata(hubWdata),
      .porTrim(porTrim), .ioDriveMode(ioDriveMode), .systemReset(systemReset), .fastOscOn(fastOscOn),
      .preciseOscOn(preciseOscOn), .preciseOsc48(preciseOsc48), .busClockOn(busClockOn),
      .cpuHalt(cpuHalt), .cpuStartAddr(cpuStartAddr), .debugMode(debugMode), .userMode(userMode));

   boot_partner_model #(.WORDS(WORDS)) partner (
      .clk(clk), .powerOn(powerOn), .holdPin(holdPin), .refsOk(refsOk), .acquire(acquire),
      .corrupt(corrupt), .hubRead(hubRead), .hubAddr(hubAddr), .supplyGood(supplyGood),
      .external_reset_n(external_reset_n), .refsReady(refsReady), .debug_acquire_pin_a(pinA),
      .debug_acquire_pin_b(pinB), .hubRdata(hubRdata), .storedSum(storedSum));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Logs hub traffic so each boot can be judged once it has finished.
   always @(posedge clk)
   begin
      if (hubRead === 1'b1)
         rdq.push_back(hubAddr);
      if (hubWrite === 1'b1)
      begin
         wrq.push_back(hubWdata);
         if (rdq.size() < WORDS)
            earlyWrite = 1'b1;
      end
      if (systemReset === 1'b1 && fastOscOn === 1'b1)
         sawFast = 1'b1;
   end

   task checkBit(input string name, input logic e, input logic g);
      comparisons++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %b seen %b", name, e, g);
         badCount++;
      end
   endtask

   task checkWord(input string name, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", name, e, g);
         badCount++;
      end
   endtask

   // Waits a bounded number of cycles: 0 reset released, 1 user, 2 debug, 3 reset raised.
   task waitCond(input int which, input int lim);
      int n;
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
         case (which)
            0: hit = (systemReset === 1'b0);
            1: hit = (userMode === 1'b1);
            2: hit = (debugMode === 1'b1);
            default: hit = (systemReset === 1'b1);
         endcase
      end
      checkBit($sformatf("wait%0d", which), 1'b1, hit);
   endtask

   task clearLog;
      rdq.delete();
      wrq.delete();
      earlyWrite = 1'b0;
      sawFast = 1'b0;
   endtask

   task restart;
      @(posedge clk);
      holdPin <= 1'b1;
      waitCond(3, 5);
      checkBit("cpuHaltInReset", 1'b1, cpuHalt);
      repeat (6) @(posedge clk);
      holdPin <= 1'b0;
      #1;
      clearLog();
   endtask

   task checkBoot(input logic toDebug);
      waitCond(0, 200);
      checkBit("sawFast", 1'b1, sawFast);
      checkBit("preciseOscOn", 1'b1, preciseOscOn);
      checkBit("busClockOn", 1'b1, busClockOn);
      checkBit("preciseOsc48", devLatch[3], preciseOsc48);
      checkBit("cpuHaltBoot", 1'b1, cpuHalt);
      checkWord("porTrim", 32'(mfgLatch), 32'(porTrim));
      waitCond(toDebug ? 2 : 1, 200);
      checkBit("userMode", ~toDebug, userMode);
      checkBit("debugMode", toDebug, debugMode);
      if (!toDebug)
      begin
         checkBit("cpuHaltUser", 1'b0, cpuHalt);
         checkWord("cpuStartAddr", 32'h0000_0000, cpuStartAddr);
      end
      checkWord("reads", WORDS, rdq.size());
      checkWord("writes", WORDS, wrq.size());
      checkBit("earlyWrite", 1'b0, earlyWrite);
      for (int i = 0; i < WORDS && i < rdq.size() && i < wrq.size(); i++)
      begin
         checkWord("readAddr", i, 32'(rdq[i]));
         checkWord("writeData", 32'(8'h3C + 8'(i) * 8'h11), 32'(wrq[i]));
      end
   endtask

   task testLatchHold;
      @(posedge clk);
      holdPin <= 1'b1;
      powerOn <= 1'b1;
      repeat (102) @(posedge clk);
      #1;
      checkWord("porTrimLoad", 32'(mfgLatch), 32'(porTrim));
      checkWord("ioDriveMode", 32'(devLatch[2:0]), 32'(ioDriveMode));
      checkBit("heldReset", 1'b1, systemReset);
      @(posedge clk);
      holdPin <= 1'b0;
      checkBoot(1'b0);
   endtask

   task testRefsLate;
      @(posedge clk);
      refsOk <= 1'b0;
      restart();
      repeat (30) @(posedge clk);
      #1;
      checkBit("refsLateReset", 1'b1, systemReset);
      @(posedge clk);
      refsOk <= 1'b1;
      checkBoot(1'b0);
   endtask

   task testBadSum;
      @(posedge clk);
      corrupt <= 1'b1;
      restart();
      waitCond(0, 200);
      waitCond(3, 200);
      checkWord("badSumWrites", 0, wrq.size());
      @(posedge clk);
      corrupt <= 1'b0;
      #1;
      clearLog();
      checkBoot(1'b0);
   endtask

   task testDebug;
      restart();
      @(posedge clk);
      acquire <= 1'b1;
      checkBoot(1'b1);
      @(posedge clk);
      acquire <= 1'b0;
   endtask

   // A second power-up with other latch contents must reload trims, drive modes and the speed choice.
   task testRepower;
      @(posedge clk);
      rst <= 1'b1;
      powerOn <= 1'b0;
      mfgLatch <= 8'hA5;
      devLatch <= 8'h04;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      powerOn <= 1'b1;
      #1;
      clearLog();
      checkBoot(1'b0);
      checkWord("ioDriveModeRepower", 32'h0000_0004, 32'(ioDriveMode));
   endtask

   task stopTest;
      if (badCount == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      rst = 1'b1;
      powerOn = 1'b0;
      holdPin = 1'b0;
      refsOk = 1'b1;
      acquire = 1'b0;
      corrupt = 1'b0;
      mfgLatch = 8'h5A;
      devLatch = 8'h0B;
      badCount = 0;
      comparisons = 0;
      clearLog();
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      testLatchHold();
      testRefsLate();
      testBadSum();
      testDebug();
      testRepower();
      stopTest();
   end

   // The tests need well under two thousand cycles.
   initial
   begin
      repeat (5000) @(posedge clk);
      badCount++;
      stopTest();
   end
endmodule
